// file: hw/tpcg_pkg.sv
/*
 * Shared constants for the two-phase clock generator: divider length,
 * phase decode positions and reset values.
 * Assumes a single oscillator clock drives every flip-flop.
 */
package tpcg_pkg;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    localparam int unsigned DIV_RATIO      = 9;
    localparam int unsigned CNT_W          = 4;
    localparam logic [3:0]  CNT_RESET      = 4'h0;
    localparam logic [3:0]  CNT_LAST       = 4'h8;

    // ------------------------------------------------------------------
    // Phase decode positions within the nine-count cycle
    // ------------------------------------------------------------------
    localparam logic [3:0]  PH1_FIRST      = 4'h0;
    localparam int unsigned PH1_WIDTH      = 2;
    localparam logic [3:0]  PH2_FIRST      = 4'h2;
    localparam int unsigned PH2_WIDTH      = 5;
    localparam logic [3:0]  EARLY_PH1_CNT  = 4'h0;
    localparam logic [3:0]  DLY_PH2_CNT    = 4'h3;

endpackage

// file: hw/tpcg_sync2.sv
/*
 * Two-stage level synchroniser with constant reset value.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module tpcg_sync2
#(
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    // Data
    input  wire logic i_d,
    output logic      o_q
);

    logic meta;
    logic next_meta;
    logic next_q;

    always_comb
    begin
        next_meta = i_d;
        next_q    = meta;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta <= RESET_VAL;
            o_q  <= RESET_VAL;
        end
        else
        begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end

endmodule

// file: hw/tpcg_top.sv
/*
 * Two-phase clock generator: divide-by-nine counter, two non-overlapping
 * phase outputs, a logic-level copy of phase two, status strobe gating,
 * and reset/ready synchronisers clocked on the delayed phase-two tick.
 * Every output comes from a flip-flop clocked by i_clk_sys.
 * Assumes i_clk_sys is the oscillator; pin inputs are asynchronous and
 * pass two flip-flops before any logic reads them.
 */
// How it works
// - Processor cycle equals nine oscillator periods from a nine-state counter.
// - Phase one is high two oscillator periods every nine.
// - Phase two is high five periods, starting two after phase one.
// - Logic-level phase two copy matches phase two exactly.
// - Status strobe is sync gated by the early first-phase timing signal.
// - Active reset input also asserts the status strobe.
// - Reset input is registered on the delayed phase-two tick to processor.
// - Ready input is registered on the delayed phase-two tick to processor.
// - Status strobe is active low via a NOR of both paths.
`timescale 1ns/1ps
module tpcg_top
    import tpcg_pkg::*;
#(
    parameter int unsigned DIV = tpcg_pkg::DIV_RATIO
)
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    // Processor and system pins
    input  wire logic i_sync,
    input  wire logic i_reset_in_b,
    input  wire logic i_ready_in,
    // Clock outputs
    output logic      o_phase1,
    output logic      o_phase2,
    output logic      o_phase2_ttl,
    // Processor control
    output logic      o_status_strobe_b,
    output logic      o_cpu_reset,
    output logic      o_cpu_ready
);
    import tpcg_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // The system reset takes effect at once but leaves on a clock edge, so
    // no flip-flop sees its release close to the clock. The rest of the
    // block uses only this released copy.
    logic rst_meta;
    logic rst_sync_b;
    logic next_rst_meta;
    logic next_rst_sync_b;

    always_comb
    begin
        next_rst_meta   = 1'b1;
        next_rst_sync_b = rst_meta;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta   <= next_rst_meta;
            rst_sync_b <= next_rst_sync_b;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Each pin passes two flip-flops, which adds two cycles from pin to
    // strobe, reset and ready.
    logic sync_s;
    logic reset_in_b_s;
    logic ready_in_s;

    tpcg_sync2 #(.RESET_VAL(1'b0)) u_sync_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (rst_sync_b),
        .i_d       (i_sync),
        .o_q       (sync_s)
    );

    tpcg_sync2 #(.RESET_VAL(1'b0)) u_sync_reset
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (rst_sync_b),
        .i_d       (i_reset_in_b),
        .o_q       (reset_in_b_s)
    );

    tpcg_sync2 #(.RESET_VAL(1'b0)) u_sync_ready
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (rst_sync_b),
        .i_d       (i_ready_in),
        .o_q       (ready_in_s)
    );

    // ------------------------------------------------------------------
    // Divider and phase decode
    // ------------------------------------------------------------------
    // True while count c lies in the window of width slots from first.
    function automatic logic in_window(input logic [3:0] c, input logic [3:0] first,
                                       input int unsigned width);
        logic [4:0] last;
        last = 5'(first) + 5'(width);
        return (5'(c) >= 5'(first)) && (5'(c) < last);
    endfunction

    // True when count c sits on one chosen slot of the cycle.
    function automatic logic at_slot(input logic [3:0] c, input logic [3:0] slot);
        return c == slot;
    endfunction

    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       ph1;
    logic       ph2;
    logic       delayed_second_phase_tick;
    logic       next_ph1;
    logic       next_ph2;
    logic       next_dly;
    logic       early_first_phase_gate;

    // Outputs are decoded from next_cnt so they change on the same edge as
    // the count; every phase pin then comes straight from a flip-flop.
    // A DIV other than nine would need new decode positions as well.
    always_comb
    begin
        next_cnt = at_slot(cnt, 4'(DIV - 1)) ? CNT_RESET : cnt + 4'h1;
        next_ph1   = in_window(next_cnt, PH1_FIRST, PH1_WIDTH);
        next_ph2   = in_window(next_cnt, PH2_FIRST, PH2_WIDTH);
        next_dly   = at_slot(next_cnt, DLY_PH2_CNT);
        // The early gate decodes the coming count, so the strobe flip-flop
        // falls on the same edge that raises phase one.
        early_first_phase_gate = at_slot(next_cnt, EARLY_PH1_CNT);
    end

    // Starting from the last state makes phase one rise on the first edge
    // after the internal reset is released.
    always_ff @(posedge i_clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cnt                       <= CNT_LAST;
            ph1                       <= 1'b0;
            ph2                       <= 1'b0;
            delayed_second_phase_tick <= 1'b0;
        end
        else
        begin
            cnt                       <= next_cnt;
            ph1                       <= next_ph1;
            ph2                       <= next_ph2;
            delayed_second_phase_tick <= next_dly;
        end
    end

    // ------------------------------------------------------------------
    // Status strobe and synchronised processor controls
    // ------------------------------------------------------------------
    logic       strobe_b;
    logic       next_strobe_b;
    logic       cpu_reset;
    logic       next_cpu_reset;
    logic       cpu_ready;
    logic       next_cpu_ready;
    logic       reset_active;

    // Reset and ready are taken only on the delayed phase-two tick, so the
    // processor sees them settled well before phase two falls.
    always_comb
    begin
        reset_active   = !reset_in_b_s;
        // Strobe low on sync in the early phase-one slot, or while reset.
        next_strobe_b  = !((sync_s && early_first_phase_gate)
                           || reset_active);
        next_cpu_reset = cpu_reset;
        next_cpu_ready = cpu_ready;
        if (delayed_second_phase_tick)
        begin
            next_cpu_reset = reset_active;
            next_cpu_ready = ready_in_s;
        end
    end

    // The strobe idles high and the processor stays in reset until a tick.
    always_ff @(posedge i_clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            strobe_b  <= 1'b1;
            cpu_reset <= 1'b1;
            cpu_ready <= 1'b0;
        end
        else
        begin
            strobe_b  <= next_strobe_b;
            cpu_reset <= next_cpu_reset;
            cpu_ready <= next_cpu_ready;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Phase two and its logic-level copy share one flip-flop, so they can
    // never drift apart.
    assign o_phase1          = ph1;
    assign o_phase2          = ph2;
    assign o_phase2_ttl      = ph2;
    assign o_status_strobe_b = strobe_b;
    assign o_cpu_reset       = cpu_reset;
    assign o_cpu_ready       = cpu_ready;

endmodule

// file: sim/tpcg_chk.sv
/* Port checker for tpcg_top.
   Assumes the bind below and steady pins around each reset. */
`timescale 1ns/1ps
module tpcg_chk
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_sync,
    input wire logic i_reset_in_b,
    input wire logic o_phase1,
    input wire logic o_phase2,
    input wire logic o_phase2_ttl,
    input wire logic o_status_strobe_b,
    input wire logic o_cpu_reset,
    input wire logic o_cpu_ready
);
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    ph1_width_a: assert property ($rose(o_phase1) |=> o_phase1 ##1 !o_phase1)
        else $error("ph1 width");
    ph1_period_a: assert property (
        $rose(o_phase1) |=> !$rose(o_phase1)[*8] ##1 $rose(o_phase1))
        else $error("ph1 period");
    ph2_lag_a: assert property (
        $rose(o_phase1) |-> ##2 $rose(o_phase2) ##0 o_phase2[*5] ##1 !o_phase2)
        else $error("ph2 timing");
    ttl_copy_a: assert property (o_phase2_ttl == o_phase2)
        else $error("ph2 copy");
    ss_gate_a: assert property (
        $rose(o_phase1) && $past(i_sync, 3) && i_reset_in_b && $past(i_reset_in_b, 5)
        |-> !o_status_strobe_b ##1 o_status_strobe_b)
        else $error("strobe missing");
    // The reset pin synchroniser starts in its active state, so the strobe
    // also stays low for the first two counts after a system reset.
    ss_only_a: assert property (
        !o_status_strobe_b && i_reset_in_b && $past(i_reset_in_b, 5) && $past(i_rst_b, 5)
        |-> $rose(o_phase1))
        else $error("strobe stray");
    ss_reset_a: assert property (
        !$past(i_reset_in_b, 3) && !$past(i_reset_in_b, 4) |-> !o_status_strobe_b)
        else $error("reset strobe");
    tick_upd_a: assert property (
        $changed(o_cpu_ready) || $changed(o_cpu_reset)
        |-> o_phase2 && $past(o_phase2, 2) && !$past(o_phase2, 3))
        else $error("off tick");
endmodule
bind tpcg_top tpcg_chk chk (.i_clk_sys, .i_rst_b, .i_sync, .i_reset_in_b, .o_phase1,
    .o_phase2, .o_phase2_ttl, .o_status_strobe_b, .o_cpu_reset, .o_cpu_ready);

// file: sim/tpcg_cpu_model.sv
/* Processor side: sync framing each machine cycle.
   Assumes phase one comes from the generator. */
`timescale 1ns/1ps
module tpcg_cpu_model
(
    input  wire logic i_clk_sys,
    input  wire logic i_phase1,
    input  wire logic i_en,
    output logic      o_sync
);
    initial o_sync = 1'b0;
    // Sync is raised once phase one ends and dropped at the next one.
    always @(negedge i_clk_sys)
    begin
        o_sync <= i_en && !i_phase1;
    end
endmodule

// file: sim/tpcg_top_tb.sv
/* Bench for tpcg_top: phases, strobe, ready and reset.
   Assumes a 50 MHz oscillator clock. */
`timescale 1ns/1ps
module tpcg_top_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_reset_in_b = 1'b1;
    logic i_ready_in = 1'b0;
    logic sync_en = 1'b0;
    logic i_sync, o_phase1, o_phase2, o_phase2_ttl, o_status_strobe_b, o_cpu_reset, o_cpu_ready;
    int error_cnt = 0;
    int checks = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    tpcg_top uut (.i_clk_sys, .i_rst_b, .i_sync, .i_reset_in_b, .i_ready_in, .o_phase1,
        .o_phase2, .o_phase2_ttl, .o_status_strobe_b, .o_cpu_reset, .o_cpu_ready);
    tpcg_cpu_model cpu (.i_clk_sys, .i_phase1(o_phase1), .i_en(sync_en), .o_sync(i_sync));
    task automatic check(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Lands at the falling edge inside the first phase-one cycle.
    task automatic to_k0;
        int n;
        n = 0;
        while (o_phase1 !== 1'b0 && n < 20)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        while (o_phase1 !== 1'b1 && n < 20)
        begin
            @(negedge i_clk_sys);
            n++;
        end
    endtask
    task automatic t_cycle(input logic s);
        sync_en = s;
        repeat (18) @(negedge i_clk_sys);
        to_k0();
        for (int c = 0; c < 9; c++)
        begin
            check(o_phase1, c < 2, "ph1");
            check(o_phase2, c > 1 && c < 7, "ph2");
            check(o_phase2_ttl, c > 1 && c < 7, "ph2 copy");
            check(o_status_strobe_b, !(s && c == 0), "strobe");
            @(negedge i_clk_sys);
        end
    endtask
    task automatic t_ready;
        to_k0();
        repeat (4) @(negedge i_clk_sys);
        i_ready_in = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        check(o_cpu_ready, 1'b0, "ready early");
        repeat (5) @(negedge i_clk_sys);
        check(o_cpu_ready, 1'b1, "ready");
        i_ready_in = 1'b0;
        repeat (9) @(negedge i_clk_sys);
        check(o_cpu_ready, 1'b0, "ready drop");
    endtask
    task automatic t_reset;
        i_reset_in_b = 1'b0;
        repeat (18) @(negedge i_clk_sys);
        check(o_cpu_reset, 1'b1, "cpu reset");
        check(o_status_strobe_b, 1'b0, "reset strobe");
        i_reset_in_b = 1'b1;
        repeat (18) @(negedge i_clk_sys);
        check(o_cpu_reset, 1'b0, "reset off");
    endtask
    initial
    begin
        repeat (6) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        t_cycle(1'b0);
        t_cycle(1'b1);
        t_ready();
        t_reset();
        test_done();
    end
    initial
    begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule
